// ### rtl/mol_pkg.sv
// Package for the motor overload limiter: widths, encodings, timing constants.
// Assumes a single core clock at the rate named below; no bus, plain ports only.
package mol_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  // Accumulator is integrated once per millisecond
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned CUR_W           = 16;
  localparam int unsigned DUR_W           = 16;
  localparam int unsigned ACC_W           = 40;
  localparam int unsigned CLOSED_LOOP_BIT = 0;
  localparam int unsigned PERMILLE        = 1000;
  localparam logic [1:0]  STATUS_OFF      = 2'h0;
  localparam logic [1:0]  STATUS_ON       = 2'h1;

  typedef enum logic [1:0] {
    MOL_ST_PEAK    = 2'h1,
    MOL_ST_LIMITED = 2'h2
  } mol_state_e;

  typedef struct packed {
    logic [CUR_W-1:0] max_motor_current_ma;
    logic [CUR_W-1:0] rated_current_ma;
    logic [CUR_W-1:0] max_current_permille;
    logic [DUR_W-1:0] peak_duration_ms;
  } mol_cfg_s;

  typedef struct packed {
    logic [ACC_W-1:0] threshold_mas;
    logic [ACC_W-1:0] overload_accumulated_value;
    logic [CUR_W-1:0] applied_current_limit;
    logic [1:0]       status;
  } mol_stat_s;

endpackage

// ### rtl/mol_tick.sv
// Millisecond tick generator for the overload limiter.
// Assumes the core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mol_tick #(
  parameter int unsigned CYCLES = mol_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Tick out
  output logic      tick
);
  // A terminal count below one would never release the pulse
  if (CYCLES < 2) begin
    $error("mol_tick: CYCLES must be at least 2");
  end

  logic [31:0] count;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count == CYCLES - 1) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/mol_limiter.sv
// I2t motor overload limiter: computes the limit, integrates the overload,
// and selects the applied current limit.
// Assumes configuration and measured current are synchronous to core_clk.
//
// Summary of operation
// [RQ1] Limiter active only when drive submode bit 0 selects closed loop.
// [RQ2] Maximum motor current is taken in milliamperes.
// [RQ3] Rated motor current is taken in milliamperes.
// [RQ4] Maximum current is given in tenths of a percent of rated current.
// [RQ5] Peak current duration is taken in milliseconds.
// [RQ6] Threshold in mAs decides between maximum and rated current.
// [RQ7] Accumulated value is readable and compared against the threshold.
// [RQ8] Applied current limit is readable at all times.
// [RQ9] Status reads zero when deactivated, one when activated.
// [RQ10] Software must set max above rated and a nonzero peak duration.
// [RQ11] Stay deactivated if max not above rated or duration zero.
// [RQ12] Limit derived from rated current, maximum current and duration.
// [RQ13] Allow maximum until limit reached, then rated current at once.
// [RQ14] Effective maximum never exceeds the maximum motor current.
// [RQ15] Accumulator rises above rated, falls below, floors at zero, rearms.
`timescale 1ns/1ps
`default_nettype none
module mol_limiter #(
  parameter int unsigned TICK_CYCLES = mol_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Configuration
  input  wire logic [7:0]                 drive_submode,
  input  wire mol_pkg::mol_cfg_s          cfg,
  // Measured motor current, mA magnitude
  input  wire logic [mol_pkg::CUR_W-1:0]  actual_current_ma,
  // State readback
  output mol_pkg::mol_stat_s              stat
);
  localparam int unsigned   AW         = mol_pkg::ACC_W;
  localparam int unsigned   CW         = mol_pkg::CUR_W;
  localparam logic [AW-1:0] ACC_MAX    = {AW{1'b1}};
  localparam logic [AW-1:0] PERMILLE_W = AW'(mol_pkg::PERMILLE);

  // The tick counter needs at least two states to produce a one-cycle pulse
  if (TICK_CYCLES < 2) begin
    $error("mol_limiter: TICK_CYCLES must be at least 2");
  end

  // A current squared; a CUR_W operand always fits the accumulator width
  function automatic logic [AW-1:0] square_ma(input logic [CW-1:0] ma);
    logic [AW-1:0] wide;
    wide = AW'(ma);
    return wide * wide;
  endfunction

  // A wrapped sum would read as a cool motor and re-arm the peak current,
  // so the sum sticks at full scale instead
  function automatic logic [AW-1:0] sat_add(input logic [AW-1:0] a,
                                            input logic [AW-1:0] b);
    logic [AW:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum[AW]) begin
      return ACC_MAX;
    end else begin
      return sum[AW-1:0];
    end
  endfunction

  // Difference floored at zero; the thermal load never reads negative
  function automatic logic [AW-1:0] floor_sub(input logic [AW-1:0] a,
                                              input logic [AW-1:0] b);
    if (a > b) begin
      return a - b;
    end else begin
      return '0;
    end
  endfunction

  // Same saturation as the sum: a long peak duration must not shrink the limit
  function automatic logic [AW-1:0] sat_mul(input logic [AW-1:0] a,
                                            input logic [AW-1:0] b);
    logic [2*AW-1:0] prod;
    prod = {{AW{1'b0}}, a} * {{AW{1'b0}}, b};
    if (prod[2*AW-1:AW] != '0) begin
      return ACC_MAX;
    end else begin
      return prod[AW-1:0];
    end
  endfunction

  // Peak current from the permille setting, clipped to the motor maximum
  function automatic logic [AW-1:0] peak_ma(input mol_pkg::mol_cfg_s c);
    logic [AW-1:0] scaled;
    scaled = (AW'(c.rated_current_ma) * AW'(c.max_current_permille)) / PERMILLE_W; // see [RQ4]
    if (scaled > AW'(c.max_motor_current_ma)) begin // see [RQ2]
      return AW'(c.max_motor_current_ma); // see [RQ14]
    end else begin
      return scaled;
    end
  endfunction

  // Millisecond time base
  logic                tick;
  // Currents and their squares, all at accumulator width
  logic [AW-1:0]       max_eff;
  logic [AW-1:0]       rated;
  logic [AW-1:0]       rated_sq;
  logic [AW-1:0]       act_sq;
  logic [AW-1:0]       excess_sq;
  // Thermal model
  logic [AW-1:0]       thr;
  logic [AW-1:0]       acc;
  logic [AW-1:0]       next_acc;
  logic                cfg_ok;
  logic                active;
  logic                trip;
  // Limit selection
  mol_pkg::mol_state_e state;
  mol_pkg::mol_state_e next_state;
  logic [CW-1:0]       next_limit;

  mol_tick #(
    .CYCLES (TICK_CYCLES)
  ) mol_tick_i (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );

  assign max_eff  = peak_ma(cfg);
  assign rated    = AW'(cfg.rated_current_ma); // see [RQ3]
  assign rated_sq = square_ma(cfg.rated_current_ma);
  assign act_sq   = square_ma(actual_current_ma);

  // Both settings must be usable before the function may switch on
  assign cfg_ok = (max_eff > rated) && (cfg.peak_duration_ms != '0); // see [RQ11]
  assign active = drive_submode[mol_pkg::CLOSED_LOOP_BIT] && cfg_ok; // see [RQ1]

  // Threshold in mA^2*ms, proportional to I2t: (Imax^2 - Irated^2) * t_peak.
  // Floored so that an unusable setting reads zero instead of a wrapped value.
  assign excess_sq = floor_sub(square_ma(CW'(max_eff)), rated_sq);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      thr <= '0;
    end else begin
      thr <= sat_mul(excess_sq, AW'(cfg.peak_duration_ms)); // see [RQ5] see [RQ12]
    end
  end

  // One integration step per tick: heat above rated, cool below, floor at zero
  always_comb begin
    next_acc = acc;
    if (tick) begin
      if (act_sq > rated_sq) begin
        next_acc = sat_add(acc, act_sq - rated_sq); // see [RQ15]
      end else begin
        next_acc = floor_sub(acc, rated_sq - act_sq); // see [RQ15]
      end
    end
  end

  // Leaving closed loop or losing a usable setup forgets the thermal history
  always_ff @(posedge core_clk) begin
    if (rst || !active) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  assign trip = (acc >= thr); // see [RQ7]

  // No hysteresis: the peak current returns as soon as the load has cooled
  // below the threshold, so a marginal load may toggle the limit on each tick
  always_comb begin
    next_state = mol_pkg::MOL_ST_PEAK;
    case (state)
      mol_pkg::MOL_ST_PEAK: begin
        if (active && trip) begin
          next_state = mol_pkg::MOL_ST_LIMITED; // see [RQ13]
        end
      end
      mol_pkg::MOL_ST_LIMITED: begin
        if (active && trip) begin
          next_state = mol_pkg::MOL_ST_LIMITED;
        end else begin
          next_state = mol_pkg::MOL_ST_PEAK; // see [RQ15]
        end
      end
      default: begin
        if (active && trip) begin
          next_state = mol_pkg::MOL_ST_LIMITED;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= mol_pkg::MOL_ST_PEAK;
    end else begin
      state <= next_state;
    end
  end

  // The limit follows the next state, so it drops at the very edge on which
  // the comparison first trips, not one cycle later
  always_comb begin
    if (next_state == mol_pkg::MOL_ST_LIMITED) begin
      next_limit = cfg.rated_current_ma; // see [RQ13]
    end else begin
      next_limit = CW'(max_eff); // see [RQ14]
    end
  end

  // Readback stage; every field leaves the same edge so the four stay coherent
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat.threshold_mas              <= thr; // see [RQ6]
      stat.overload_accumulated_value <= acc; // see [RQ7]
      stat.applied_current_limit      <= next_limit; // see [RQ8]
      stat.status <= active ? mol_pkg::STATUS_ON : mol_pkg::STATUS_OFF; // see [RQ9]
    end
  end
endmodule
`default_nettype wire

// ### test/mol_limiter_sva.sv
// Port-level assertions for the overload limiter.
// Assumes the synchronous reset and the package's status codes.
`timescale 1ns/1ps
`default_nettype none
module mol_limiter_sva (
  // Clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst,
  // Watched ports
  input wire logic [7:0]                drive_submode,
  input wire mol_pkg::mol_cfg_s         cfg,
  input wire logic [mol_pkg::CUR_W-1:0] actual_current_ma,
  input wire mol_pkg::mol_stat_s        stat
);
  logic [31:0] pk;
  logic [15:0] eff;
  // Effective maximum, capped by the motor limit
  assign pk = 32'(cfg.rated_current_ma) * 32'(cfg.max_current_permille)
              / 32'(mol_pkg::PERMILLE);
  assign eff = (pk > 32'(cfg.max_motor_current_ma)) ? cfg.max_motor_current_ma : pk[15:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_open_loop_off: assert property (!drive_submode[0] |=>
    stat.status == mol_pkg::STATUS_OFF && stat.applied_current_limit == $past(eff))
    else $error("open loop not idle");
  a_bad_cfg_off: assert property (
    eff <= cfg.rated_current_ma || cfg.peak_duration_ms == 16'h0000
    |=> stat.status == mol_pkg::STATUS_OFF) else $error("bad setup not idle");
  a_good_cfg_on: assert property (
    drive_submode[0] && eff > cfg.rated_current_ma && cfg.peak_duration_ms != 16'h0000
    |=> stat.status == mol_pkg::STATUS_ON) else $error("not on");
  a_limit_cap: assert property (
    stat.applied_current_limit <= $past(cfg.max_motor_current_ma))
    else $error("limit above motor max");
  // Status, load, threshold and limit leave one register stage together,
  // so the limit is judged against the load and threshold shown beside it
  a_trip_rated: assert property (
    stat.status == mol_pkg::STATUS_ON && stat.overload_accumulated_value >= stat.threshold_mas
    |-> stat.applied_current_limit == $past(cfg.rated_current_ma)) else $error("no trip");
  a_peak_allowed: assert property (
    stat.status == mol_pkg::STATUS_ON && stat.overload_accumulated_value < stat.threshold_mas
    |-> stat.applied_current_limit == $past(eff)) else $error("peak withheld");
  a_acc_clear: assert property (stat.status == mol_pkg::STATUS_OFF [*2]
    |-> stat.overload_accumulated_value == 40'h0) else $error("acc kept while off");
  // A load step shown now was integrated two edges ago, with that cycle's current
  a_acc_rises: assert property (
    stat.status == mol_pkg::STATUS_ON && $past(stat.status) == mol_pkg::STATUS_ON
    && $changed(stat.overload_accumulated_value)
    && $past(actual_current_ma, 2) > $past(cfg.rated_current_ma, 2)
    |-> stat.overload_accumulated_value > $past(stat.overload_accumulated_value))
    else $error("acc fell");
endmodule
bind mol_limiter mol_limiter_sva mol_limiter_sva_i (.core_clk(core_clk), .rst(rst),
  .drive_submode(drive_submode), .cfg(cfg), .actual_current_ma(actual_current_ma), .stat(stat));
`default_nettype wire

// ### test/mol_limiter_tb_top.sv
// Self-checking bench for the overload limiter on plain ports.
// Assumes a 20-cycle tick so a millisecond is short.
`timescale 1ns/1ps
`default_nettype none
module mol_limiter_tb_top;
  localparam int unsigned TK = 20;
  localparam logic [63:0] CF = 64'h05DC_03E8_07D0_0005;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         sub = 8'h00;
  mol_pkg::mol_cfg_s  cfg = '0;
  logic [15:0]        cur = 16'h0000;
  mol_pkg::mol_stat_s stat;
  int                 bad_count = 0;
  int                 check_count = 0;
  int                 cyc = 0;
  always #50 core_clk = ~core_clk;
  mol_limiter #(.TICK_CYCLES(TK)) mol_limiter_i (.core_clk(core_clk), .rst(rst),
    .drive_submode(sub), .cfg(cfg), .actual_current_ma(cur), .stat(stat));
  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic drive(input logic [7:0] s, input logic [63:0] c, input logic [15:0] i, int n);
    @(negedge core_clk);
    sub = s;
    cfg = c;
    cur = i;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard, well above the run's length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    drive(8'h00, CF, 16'h05DC, 3);
    chk("status", stat.status, 40'h0);
    chk("limit", stat.applied_current_limit, 40'h5DC);
    $display("open loop done");
    // Peak 1500 mA over rated 1000 mA for 5 ms: threshold (1500^2 - 1000^2) * 5,
    // and each tick at 1500 mA adds 1250000; ticks land 3 times in this wait
    drive(8'h01, CF, 16'h05DC, 3 * TK);
    chk("status", stat.status, 40'h1);
    chk("peak", stat.applied_current_limit, 40'h5DC);
    chk("threshold", stat.threshold_mas, 40'h5F5E10);
    chk("acc three ticks", stat.overload_accumulated_value, 40'h393870);
    drive(8'h01, CF, 16'h05DC, 5 * TK);
    chk("tripped", stat.applied_current_limit, 40'h3E8);
    chk("acc eight ticks", stat.overload_accumulated_value, 40'h989680);
    drive(8'h01, CF, 16'h0000, 14 * TK);
    chk("drained", stat.overload_accumulated_value, 40'h0);
    chk("rearmed", stat.applied_current_limit, 40'h5DC);
    $display("overload done");
    drive(8'h01, 64'h05DC_03E8_07D0_0000, 16'h0000, 3);
    chk("no dur", stat.status, 40'h0);
    drive(8'h01, 64'h05DC_03E8_0384_0005, 16'h0000, 3);
    chk("low max", stat.status, 40'h0);
    chk("low lim", stat.applied_current_limit, 40'h384);
    $display("setup done");
    report_and_stop();
  end
endmodule
`default_nettype wire
